// ==== include/ior_consts.svh ====
// Constants for the inclusive-OR instruction execution block
`ifndef IOR_CONSTS_SVH
`define IOR_CONSTS_SVH
`define IOR_LIT_OPC        8'h09
`define IOR_FILE_OPC6      6'h04
`define IOR_IDX_MAX        8'h5F
`define IOR_ACCESS_SPLIT   8'h60
`define IOR_ACCESS_HI_BANK 4'hF
`define IOR_ACC_RST        8'h00
`endif

// ==== include/ior_pkg.sv ====
// Types shared by the inclusive-OR execution block
`default_nettype none
package ior_pkg;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_LIT  = 2'b01,
    OP_FILE = 2'b10
  } op_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } instr_t;

  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  data;
  } file_wr_t;

  typedef struct packed {
    logic [7:0] acc;
    logic       neg;
    logic       zero;
    file_wr_t   fw;
    logic       done;
  } state_t;
endpackage : ior_pkg
`default_nettype wire

// ==== rtl/ior_exec.sv ====
// Decode and single-cycle execution of the two inclusive-OR instructions
`default_nettype none
`include "ior_consts.svh"

module ior_exec (
  input  wire logic              clk,          // Core clock, 200 MHz
  input  wire logic              rst_n,        // Synchronous reset, active low
  input  wire ior_pkg::instr_t   instr,        // Instruction word with valid
  input  wire logic              ext_en,       // Extended instruction set enabled
  input  wire logic [3:0]        bank_pointer, // Bank select pointer
  input  wire logic [11:0]       index_base,   // Index register for literal offset
  output logic [11:0]            file_raddr,   // File read address (combinational)
  input  wire logic [7:0]        file_rdata,   // File read data, same cycle
  output ior_pkg::file_wr_t      file_wr,      // File write-back, registered
  output logic [7:0]             acc,          // Accumulator
  output logic                   neg_flag,     // Negative flag
  output logic                   zero_flag,    // Zero flag
  output logic                   done          // Pulse: an OR retired
);

  // ************************************************************
  // Decode
  // ************************************************************
  function automatic ior_pkg::op_t decode(input logic [15:0] w);
    if (w[15:8] == `IOR_LIT_OPC) begin
      decode = ior_pkg::OP_LIT;
    end else if (w[15:10] == `IOR_FILE_OPC6) begin
      decode = ior_pkg::OP_FILE;
    end else begin
      decode = ior_pkg::OP_NONE;
    end
  endfunction : decode

  function automatic logic [11:0] file_addr(input logic a, input logic [7:0] f,
                                           input logic ext, input logic [3:0] bp,
                                           input logic [11:0] idx);
    if (a) begin
      file_addr = {bp, f};
    end else if (ext && (f <= `IOR_IDX_MAX)) begin
      file_addr = idx + {4'h0, f};
    end else if (f < `IOR_ACCESS_SPLIT) begin
      file_addr = {4'h0, f};
    end else begin
      file_addr = {`IOR_ACCESS_HI_BANK, f}; // Upper access half maps to the top bank
    end
  endfunction : file_addr

  ior_pkg::op_t   op;
  ior_pkg::state_t s_q;
  ior_pkg::state_t s_d;
  logic [7:0]     result;

  assign op         = instr.valid ? decode(instr.word) : ior_pkg::OP_NONE;
  assign file_raddr = file_addr(instr.word[8], instr.word[7:0], ext_en,
                                bank_pointer, index_base);

  // ************************************************************
  // Execute
  // ************************************************************
  always_comb begin
    s_d       = s_q;
    s_d.fw.we = 1'b0;
    s_d.done  = 1'b0;
    result    = 8'h00;
    case (op)
      ior_pkg::OP_LIT: begin
        result   = s_q.acc | instr.word[7:0];
        s_d.acc  = result;
        s_d.done = 1'b1;
      end
      ior_pkg::OP_FILE: begin
        result = s_q.acc | file_rdata;
        if (instr.word[9]) begin
          s_d.fw.we   = 1'b1;
          s_d.fw.addr = file_raddr;
          s_d.fw.data = result;
        end else begin
          s_d.acc = result;
        end
        s_d.done = 1'b1;
      end
      default: begin
        result = 8'h00;
      end
    endcase
    if (op != ior_pkg::OP_NONE) begin
      s_d.neg  = result[7];
      s_d.zero = (result == 8'h00);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '{acc: `IOR_ACC_RST, neg: 1'b0, zero: 1'b0,
               fw: '{we: 1'b0, addr: 12'h000, data: 8'h00}, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign acc       = s_q.acc;
  assign neg_flag  = s_q.neg;
  assign zero_flag = s_q.zero;
  assign file_wr   = s_q.fw;
  assign done      = s_q.done;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  lit_or_acc_a: assert property (
    instr.valid && instr.word[15:8] == 8'h09
    |=> acc == ($past(acc) | $past(instr.word[7:0])))
    else $error("literal OR result wrong");

  file_decode_a: assert property (
    instr.valid && instr.word[15:10] == 6'h04 |=> done)
    else $error("file OR not retired");

  dest_file_a: assert property (
    instr.valid && instr.word[15:10] == 6'h04 && instr.word[9]
    |=> file_wr.we && file_wr.data == ($past(acc) | $past(file_rdata)) && $stable(acc))
    else $error("file write-back wrong");

  dest_acc_a: assert property (
    instr.valid && instr.word[15:10] == 6'h04 && !instr.word[9]
    |=> !file_wr.we && acc == ($past(acc) | $past(file_rdata)))
    else $error("accumulator destination wrong");

  bank_addr_a: assert property (
    instr.word[8] |-> file_raddr == {bank_pointer, instr.word[7:0]})
    else $error("bank address wrong");

  access_addr_a: assert property (
    !instr.word[8] && !ext_en && instr.word[7:0] < 8'h60
    |-> file_raddr == {4'h0, instr.word[7:0]})
    else $error("access address wrong");

  indexed_addr_a: assert property (
    !instr.word[8] && ext_en && instr.word[7:0] <= 8'h5F
    |-> file_raddr == index_base + {4'h0, instr.word[7:0]})
    else $error("indexed address wrong");

  flags_set_a: assert property (
    done |-> neg_flag == (file_wr.we ? file_wr.data[7] : acc[7])
             && zero_flag == ((file_wr.we ? file_wr.data : acc) == 8'h00))
    else $error("flags wrong");

  idle_hold_a: assert property (
    !instr.valid |=> !done && $stable(acc) && !file_wr.we)
    else $error("state moved while idle");

  lit_cov_c:  cover property (instr.valid && instr.word[15:8] == 8'h09 ##1 zero_flag);
  wb_cov_c:   cover property (file_wr.we && neg_flag);
  idx_cov_c:  cover property (op == ior_pkg::OP_FILE && ext_en && !instr.word[8]
                              && instr.word[7:0] <= 8'h5F);
  bank_cov_c: cover property (op == ior_pkg::OP_FILE && instr.word[8]);

endmodule : ior_exec
`default_nettype wire

// ==== dv/test_inclusive_or_instruction_exec.sv ====
// Self-checking bench for the inclusive-OR execution block
`default_nettype none
module test_inclusive_or_instruction_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  ior_pkg::instr_t   instr = '0;
  logic              ext_en = 1'b0;
  logic [3:0]        bank_pointer = 4'h0;
  logic [11:0]       index_base = 12'h000;
  logic [11:0]       file_raddr;
  logic [7:0]        file_rdata;
  ior_pkg::file_wr_t file_wr;
  logic [7:0]        acc;
  logic [7:0]        acc_m;
  logic              neg_flag, zero_flag, done;
  int                failures = 0;
  int                checks_done = 0;
  always #2.5 clk = ~clk;
  // Data depends on every address bit, so a wrong bank gives a wrong result
  assign file_rdata = file_raddr[7:0] ^ {file_raddr[11:8], file_raddr[11:8]};
  ior_exec u_ior_exec (.clk(clk), .rst_n(rst_n), .instr(instr), .ext_en(ext_en),
    .bank_pointer(bank_pointer), .index_base(index_base), .file_raddr(file_raddr),
    .file_rdata(file_rdata), .file_wr(file_wr), .acc(acc), .neg_flag(neg_flag),
    .zero_flag(zero_flag), .done(done));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic do_reset();
    @(posedge clk) rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    acc_m = 8'h00;
    #1 chk({acc, neg_flag, zero_flag, done, file_wr.we}, 21'h0);
  endtask : do_reset
  // Issue one word and compare everything it should change
  task automatic run(input logic [15:0] w, input logic [11:0] a);
    logic [7:0] r;
    logic       lit;
    lit = (w[15:8] == 8'h09);
    @(posedge clk) instr <= '{1'b1, w};
    #1 if (!lit) chk(file_raddr, a);
    r = acc_m | (lit ? w[7:0] : (a[7:0] ^ {a[11:8], a[11:8]}));
    @(posedge clk) instr <= '{1'b0, w};
    #1 chk({done, neg_flag, zero_flag}, {1'b1, r[7], r == 8'h00});
    chk(file_wr.we, !lit && w[9]);
    if (!lit && w[9]) chk({file_wr.addr, file_wr.data}, {a, r});
    else acc_m = r;
    chk(acc, acc_m);
  endtask : run
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic literal_test();
    run(16'h0900, 12'h000);
    run(16'h099A, 12'h000);
    run(16'h0935, 12'h000);
    $display("literal test done");
  endtask : literal_test
  task automatic bank_test();
    @(posedge clk) bank_pointer <= 4'h3;
    run(16'h1155, 12'h355);
    run(16'h1070, 12'hF70);
    run(16'h1212, 12'h012);
    run(16'h13A5, 12'h3A5);
    $display("bank test done");
  endtask : bank_test
  task automatic index_test();
    @(posedge clk) begin
      ext_en     <= 1'b1;
      index_base <= 12'hFF0;
    end
    // The index sum wraps at 12 bits
    run(16'h105F, 12'h04F);
    run(16'h1260, 12'hF60);
    run(16'h1110, 12'h310);
    $display("index test done");
  endtask : index_test
  task automatic refuse_test();
    logic [16:0] bad [3];
    bad = '{17'h1_1435, 17'h1_0A35, 17'h0_09FF};
    foreach (bad[i]) begin
      @(posedge clk) instr <= bad[i];
      @(posedge clk) #1 chk({done, file_wr.we, acc}, {2'b00, acc_m});
    end
    @(posedge clk) instr <= '0;
    $display("refuse test done");
  endtask : refuse_test
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    do_reset();
    literal_test();
    bank_test();
    do_reset();
    index_test();
    refuse_test();
    print_verdict();
  end
  // About 47 cycles are expected; the limit leaves wide margin
  initial begin
    #3000;
    failures++;
    print_verdict();
  end
endmodule : test_inclusive_or_instruction_exec
`default_nettype wire
